// file: rtl/ests_pkg.sv
// constants, types and helpers of the stream traffic shaper
package ests_pkg;
  localparam logic [7:0] R_CTRL     = 8'h00;
  localparam logic [7:0] R_LD_START = 8'h04;
  localparam logic [7:0] R_LD_END   = 8'h08;
  localparam logic [7:0] R_LD_STEP  = 8'h0c;
  localparam logic [7:0] R_LD_DUR   = 8'h10;
  localparam logic [7:0] R_FS_START = 8'h14;
  localparam logic [7:0] R_FS_END   = 8'h18;
  localparam logic [7:0] R_FS_STEP  = 8'h1c;
  localparam logic [7:0] R_FS_DUR   = 8'h20;
  localparam logic [7:0] R_TRAF_DUR = 8'h24;
  localparam logic [7:0] R_ENC      = 8'h28;
  localparam logic [7:0] R_B_DUTY   = 8'h2c;
  localparam logic [7:0] R_B_PERIOD = 8'h30;
  localparam logic [7:0] R_B_FSZ    = 8'h34;
  localparam logic [7:0] R_B_CNT    = 8'h38;
  localparam logic [7:0] R_STATUS   = 8'h3c;
  localparam logic [7:0] R_CUR_LOAD = 8'h40;
  localparam logic [7:0] R_CUR_FSZ  = 8'h44;
  localparam logic [7:0] R_FRAMES   = 8'h48;
  // control register fields
  localparam int CTL_RUN   = 0;
  localparam int CTL_BURST = 1;
  localparam int CTL_PROF  = 2;
  localparam int CTL_RAMP  = 4;
  localparam int CTL_RMODE = 5;
  localparam int CTL_FMODE = 7;
  localparam int CTL_DMODE = 9;
  localparam int CTL_BMODE = 11;
  localparam int CTL_MBPS  = 13;
  localparam int ENC_CHAN  = 8;
  typedef enum logic [1:0] {PR_DATA, PR_VIDEO, PR_VOICE} ests_prof_t;
  typedef enum logic [1:0] {RM_KEEP, RM_REPEAT, RM_INVERT} ests_rmode_t;
  typedef enum logic [1:0] {FM_CONST, FM_STEP, FM_RAND} ests_fmode_t;
  typedef enum logic [1:0] {DM_CONT, DM_SECS, DM_FRAMES} ests_dmode_t;
  typedef enum logic [1:0] {BM_OFF, BM_CONST, BM_NB} ests_bmode_t;
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} ests_state_t;
  localparam logic [15:0] WIRE_EXTRA = 16'h0014;
  localparam logic [47:0] PCT_FULL   = 48'h0000_0000_2710;
  localparam logic [47:0] LINE_MBPS  = 48'h0000_0000_2710;
  localparam logic [47:0] LINE_BPC   = 48'h0000_0000_0005;
  localparam logic [39:0] DUTY_DIV   = 40'h00_0000_0064;
  localparam logic [15:0] LFSR_SEED  = 16'hace1;
  localparam logic [15:0] LFSR_TAPS  = 16'hb400;
  localparam int unsigned MS_NS      = 32'h000f_4240;
  localparam int unsigned CLK_NS     = 32'h0000_0004;
  localparam logic [9:0]  MS_PER_S   = 10'h3e8;
  // per-channel load of each encoding, in line-load units
  function automatic logic [15:0] enc_rate(input logic [3:0] e);
    case (e)
      4'h0:    enc_rate = 16'h0064;
      4'h1:    enc_rate = 16'h0190;
      4'h2:    enc_rate = 16'h0008;
      4'h3:    enc_rate = 16'h0002;
      default: enc_rate = 16'h0001;
    endcase
  endfunction
  // one step toward tgt, never past it
  function automatic logic [15:0] step_to(input logic [15:0] cur,
      input logic [15:0] tgt, input logic [15:0] st);
    if (cur < tgt)
      step_to = (tgt - cur <= st) ? tgt : 16'(cur + st);
    else
      step_to = (cur - tgt <= st) ? tgt : 16'(cur - st);
  endfunction
endpackage

// file: rtl/ests_shaper.sv
// stream traffic shaper: apb registers, load ramp, sizes, bursts
// How it works
// - normal mode paces plain frames; burst mode makes bursts
// - data profile load is constant or a ramp, selected by software
// - video and voice load is encoding rate times channel count
// - ramp starts at start load, steps by step size each step time
// - ramp end: keep end load, restart ramp, or reverse direction
// - load in percent or mbps; zero load stops the stream
// - constant size mode sends every frame at start size
// - stepped size goes start to end by step, each held seconds
// - continuous duration restarts the size sequence endlessly
// - seconds duration ends traffic when the period has passed
// - frame duration ends traffic once sent frames equal count
// - random size mode draws sizes evenly between start and end
// - frame size holds headers and payload, no preamble or gap
// - burst mode sends only bursts; burst off stops the stream
// - constant bursts keep fixed data and gap length from duty
// - counted bursts stop the stream after the set number
// - burst length counts burst frame size plus 20 bytes each
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module ests_shaper
  import ests_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_NS / CLK_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [15:0] tx_size
);
  logic [15:0] ctrl, ld_start, ld_end, ld_step, ld_dur;
  logic [15:0] fs_start, fs_end, fs_step, fs_dur, enc_cfg, b_fsz, b_cnt;
  logic [31:0] traf_dur, b_period;
  logic [6:0]  b_duty;
  ests_state_t st;
  logic        run_q, ramp_up, pend, perr;
  logic [15:0] cur_load, cur_fsz, lfsr, ld_ms, fs_sec, bursts;
  logic [9:0]  sec_ms;
  logic [31:0] ms_cnt, tot_sec, frames, ptime, bsent;
  logic [47:0] credit;
  logic [15:0] next_ctrl, next_ld_start, next_ld_end, next_ld_step;
  logic [15:0] next_ld_dur, next_fs_start, next_fs_end, next_fs_step;
  logic [15:0] next_fs_dur, next_enc_cfg, next_b_fsz, next_b_cnt;
  logic [31:0] next_traf_dur, next_b_period, next_prdata;
  logic [6:0]  next_b_duty;
  ests_state_t next_st;
  logic        next_run_q, next_ramp_up, next_pend, next_perr;
  logic [15:0] next_cur_load, next_cur_fsz, next_lfsr, next_ld_ms;
  logic [15:0] next_fs_sec, next_bursts, next_tx_size;
  logic [9:0]  next_sec_ms;
  logic [31:0] next_ms_cnt, next_tot_sec, next_frames;
  logic [31:0] next_ptime, next_bsent;
  logic [47:0] next_credit;
  logic        issue, done;
  logic [15:0] eff_load, size_sel, rnd_sz, ld_tgt;
  logic [47:0] cost;
  logic [31:0] dlen;
  logic [32:0] rnd_prod;
  logic [1:0]  prof, rmode, fmode, dmode, bmode;
  logic        is_burst, is_ramp, ms_tick, sec_tick, ld_due, fs_due, wrap;

  assign prof     = ctrl[CTL_PROF +: 2];
  assign rmode    = ctrl[CTL_RMODE +: 2];
  assign fmode    = ctrl[CTL_FMODE +: 2];
  assign dmode    = ctrl[CTL_DMODE +: 2];
  assign bmode    = ctrl[CTL_BMODE +: 2];
  assign is_burst = ctrl[CTL_BURST];
  assign is_ramp  = ctrl[CTL_RAMP];
  assign pready   = psel & penable;
  assign pslverr  = pready & perr;
  assign tx_valid = pend;
  assign ms_tick  = (ms_cnt >= CYC_PER_MS - 1);
  assign sec_tick = ms_tick && (sec_ms >= MS_PER_S - 10'h001);
  assign ld_due   = ms_tick && (17'(ld_ms) + 17'h0_0001 >= 17'(ld_dur));
  assign fs_due   = sec_tick && (17'(fs_sec) + 17'h0_0001 >= 17'(fs_dur));
  assign ld_tgt   = ramp_up ? ld_end : ld_start;
  assign wrap     = 48'(ptime) + LINE_BPC >= 48'(b_period);
  assign eff_load = (prof == PR_DATA) ? cur_load :
                    16'(enc_rate(enc_cfg[3:0]) * 16'(enc_cfg[15:ENC_CHAN]));
  assign rnd_prod = 33'(lfsr) * 33'(17'(fs_end) - 17'(fs_start) + 17'h0_0001);
  assign rnd_sz   = (fs_end > fs_start) ? 16'(fs_start + rnd_prod[31:16])
                                        : fs_start;
  always_comb begin
    if (is_burst || prof != PR_DATA || fmode == FM_CONST)
      size_sel = is_burst ? b_fsz : fs_start;
    else if (fmode == FM_STEP)
      size_sel = cur_fsz;
    else
      size_sel = rnd_sz;
  end
  // gap and preamble only in wire cost
  assign cost = (48'(size_sel) + 48'(WIRE_EXTRA)) *
                (ctrl[CTL_MBPS] ? LINE_MBPS : PCT_FULL);
  assign dlen = 32'((40'(b_period) * 40'(b_duty)) / DUTY_DIV);

  always_comb begin
    next_ctrl = ctrl; next_ld_start = ld_start; next_ld_end = ld_end;
    next_ld_step = ld_step; next_ld_dur = ld_dur; next_fs_start = fs_start;
    next_fs_end = fs_end; next_fs_step = fs_step; next_fs_dur = fs_dur;
    next_enc_cfg = enc_cfg; next_b_fsz = b_fsz; next_b_cnt = b_cnt;
    next_traf_dur = traf_dur; next_b_period = b_period;
    next_b_duty = b_duty; next_prdata = prdata; next_perr = perr;
    next_st = st; next_ramp_up = ramp_up; next_pend = pend;
    next_cur_load = cur_load; next_cur_fsz = cur_fsz; next_ld_ms = ld_ms;
    next_fs_sec = fs_sec; next_bursts = bursts; next_tx_size = tx_size;
    next_tot_sec = tot_sec; next_frames = frames; next_ptime = ptime;
    next_bsent = bsent; next_credit = credit;
    next_run_q = ctrl[CTL_RUN];
    issue = 1'b0;
    done = 1'b0;
    // apb read data and error latched in the setup phase
    if (psel && !penable) begin
      next_perr = 1'b0;
      if (paddr == R_CTRL) next_prdata = {16'h0000, ctrl};
      else if (paddr == R_LD_START) next_prdata = {16'h0000, ld_start};
      else if (paddr == R_LD_END) next_prdata = {16'h0000, ld_end};
      else if (paddr == R_LD_STEP) next_prdata = {16'h0000, ld_step};
      else if (paddr == R_LD_DUR) next_prdata = {16'h0000, ld_dur};
      else if (paddr == R_FS_START) next_prdata = {16'h0000, fs_start};
      else if (paddr == R_FS_END) next_prdata = {16'h0000, fs_end};
      else if (paddr == R_FS_STEP) next_prdata = {16'h0000, fs_step};
      else if (paddr == R_FS_DUR) next_prdata = {16'h0000, fs_dur};
      else if (paddr == R_TRAF_DUR) next_prdata = traf_dur;
      else if (paddr == R_ENC) next_prdata = {16'h0000, enc_cfg};
      else if (paddr == R_B_DUTY) next_prdata = {25'h000_0000, b_duty};
      else if (paddr == R_B_PERIOD) next_prdata = b_period;
      else if (paddr == R_B_FSZ) next_prdata = {16'h0000, b_fsz};
      else if (paddr == R_B_CNT) next_prdata = {16'h0000, b_cnt};
      else if (paddr == R_STATUS)
        next_prdata = {29'h0000_0000, pend, st == ST_DONE, st == ST_RUN};
      else if (paddr == R_CUR_LOAD) next_prdata = {16'h0000, eff_load};
      else if (paddr == R_CUR_FSZ) next_prdata = {16'h0000, cur_fsz};
      else if (paddr == R_FRAMES) next_prdata = frames;
      else begin
        next_prdata = 32'h0000_0000;
        next_perr = 1'b1;
      end
    end
    if (pready && pwrite && !perr) begin
      if (paddr == R_CTRL) next_ctrl = pwdata[15:0];
      else if (paddr == R_LD_START) next_ld_start = pwdata[15:0];
      else if (paddr == R_LD_END) next_ld_end = pwdata[15:0];
      else if (paddr == R_LD_STEP) next_ld_step = pwdata[15:0];
      else if (paddr == R_LD_DUR) next_ld_dur = pwdata[15:0];
      else if (paddr == R_FS_START) next_fs_start = pwdata[15:0];
      else if (paddr == R_FS_END) next_fs_end = pwdata[15:0];
      else if (paddr == R_FS_STEP) next_fs_step = pwdata[15:0];
      else if (paddr == R_FS_DUR) next_fs_dur = pwdata[15:0];
      else if (paddr == R_TRAF_DUR) next_traf_dur = pwdata;
      else if (paddr == R_ENC) next_enc_cfg = pwdata[15:0];
      else if (paddr == R_B_DUTY) next_b_duty = pwdata[6:0];
      else if (paddr == R_B_PERIOD) next_b_period = pwdata;
      else if (paddr == R_B_FSZ) next_b_fsz = pwdata[15:0];
      else if (paddr == R_B_CNT) next_b_cnt = pwdata[15:0];
    end
    // frame taken by the link
    if (pend && tx_ready) begin
      next_pend = 1'b0;
      next_frames = frames + 32'h0000_0001;
    end
    if (ctrl[CTL_RUN] && !run_q) begin
      next_st = ST_RUN;
      next_cur_load = is_ramp ? ld_start : ld_end;
      next_ramp_up = 1'b1;
      next_cur_fsz = fs_start;
      next_ld_ms = '0; next_fs_sec = '0; next_tot_sec = '0;
      next_frames = '0; next_ptime = '0; next_bsent = '0;
      next_bursts = '0; next_credit = '0;
    end else if (!ctrl[CTL_RUN]) begin
      next_st = ST_IDLE;
    end else if (st == ST_RUN) begin
      if (!is_ramp) begin
        next_cur_load = ld_end;
      end else if (ms_tick) begin
        next_ld_ms = ld_due ? 16'h0000 : 16'(ld_ms + 16'h0001);
        if (ld_due && cur_load != ld_tgt) begin
          next_cur_load = step_to(cur_load, ld_tgt, ld_step);
        end else if (ld_due) begin
          case (rmode)
            RM_REPEAT: next_cur_load = ld_start;
            RM_INVERT: begin
              next_ramp_up = !ramp_up;
              next_cur_load = step_to(cur_load,
                                ramp_up ? ld_start : ld_end, ld_step);
            end
            default: next_cur_load = cur_load;
          endcase
        end
      end
      if (sec_tick) begin
        next_tot_sec = tot_sec + 32'h0000_0001;
        next_fs_sec = fs_due ? 16'h0000 : 16'(fs_sec + 16'h0001);
      end
      if (fs_due) begin
        next_cur_fsz = (cur_fsz == fs_end) ? fs_start
                                           : step_to(cur_fsz, fs_end, fs_step);
      end
      if (dmode == DM_SECS && next_tot_sec >= traf_dur) done = 1'b1;
      if (dmode == DM_FRAMES && next_frames >= traf_dur) done = 1'b1;
      if (is_burst && bmode == BM_NB && bursts >= b_cnt) done = 1'b1;
      if (done) begin
        next_st = ST_DONE;
      end else if (!is_burst) begin
        if (eff_load == 16'h0000) begin
          next_credit = '0;
        end else if (credit < cost) begin
          next_credit = credit + 48'(eff_load) * LINE_BPC;
        end else if (!next_pend) begin
          issue = 1'b1;
          next_credit = credit - cost;
        end
      end else if (bmode != BM_OFF) begin
        if (wrap) begin
          next_ptime = '0;
          next_bsent = '0;
          next_bursts = 16'(bursts + 16'h0001);
        end else begin
          next_ptime = 32'(48'(ptime) + LINE_BPC);
          if (bsent < dlen && !next_pend) begin
            issue = 1'b1;
            next_bsent = bsent + 32'(b_fsz) + 32'(WIRE_EXTRA);
          end
        end
      end
    end
    if (issue) begin
      next_pend = 1'b1;
      next_tx_size = size_sel;
    end
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    next_sec_ms = sec_tick ? 10'h000 :
                  ms_tick ? 10'(sec_ms + 10'h001) : sec_ms;
    next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
    if (ctrl[CTL_RUN] && !run_q) begin
      next_ms_cnt = '0;
      next_sec_ms = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl <= '0; ld_start <= '0; ld_end <= '0; ld_step <= '0;
      ld_dur <= '0; fs_start <= '0; fs_end <= '0; fs_step <= '0;
      fs_dur <= '0; enc_cfg <= '0; b_fsz <= '0; b_cnt <= '0;
      traf_dur <= '0; b_period <= '0; b_duty <= '0; prdata <= '0;
      perr <= 1'b0; st <= ST_IDLE; run_q <= 1'b0; ramp_up <= 1'b1;
      pend <= 1'b0; cur_load <= '0; cur_fsz <= '0; lfsr <= LFSR_SEED;
      ld_ms <= '0; fs_sec <= '0; bursts <= '0; tx_size <= '0;
      sec_ms <= '0; ms_cnt <= '0; tot_sec <= '0; frames <= '0;
      ptime <= '0; bsent <= '0; credit <= '0;
    end else begin
      ctrl <= next_ctrl; ld_start <= next_ld_start; ld_end <= next_ld_end;
      ld_step <= next_ld_step; ld_dur <= next_ld_dur;
      fs_start <= next_fs_start; fs_end <= next_fs_end;
      fs_step <= next_fs_step; fs_dur <= next_fs_dur;
      enc_cfg <= next_enc_cfg; b_fsz <= next_b_fsz; b_cnt <= next_b_cnt;
      traf_dur <= next_traf_dur; b_period <= next_b_period;
      b_duty <= next_b_duty; prdata <= next_prdata; perr <= next_perr;
      st <= next_st; run_q <= next_run_q; ramp_up <= next_ramp_up;
      pend <= next_pend; cur_load <= next_cur_load;
      cur_fsz <= next_cur_fsz; lfsr <= next_lfsr; ld_ms <= next_ld_ms;
      fs_sec <= next_fs_sec; bursts <= next_bursts;
      tx_size <= next_tx_size; sec_ms <= next_sec_ms;
      ms_cnt <= next_ms_cnt; tot_sec <= next_tot_sec;
      frames <= next_frames; ptime <= next_ptime; bsent <= next_bsent;
      credit <= next_credit;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic running;
  assign running = st == ST_RUN && ctrl[CTL_RUN] && run_q;

  property p_off_quiet;
    (!is_burst && eff_load == 16'h0000 && !pend) |=> !pend;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("frame issued with load off");
  property p_boff;
    (is_burst && bmode == BM_OFF && !pend) |=> !pend;
  endproperty
  a_boff: assert property (p_boff)
    else $error("frame issued with burst off");
  property p_const_sz;
    (issue && !is_burst && prof == PR_DATA && fmode == FM_CONST)
      |=> tx_size == $past(fs_start);
  endproperty
  a_const_sz: assert property (p_const_sz)
    else $error("constant size not start size");
  property p_rand_sz;
    (issue && !is_burst && prof == PR_DATA && fmode == FM_RAND &&
     fs_start < fs_end) |=> (tx_size >= fs_start && tx_size <= fs_end);
  endproperty
  a_rand_sz: assert property (p_rand_sz)
    else $error("random size out of range");
  property p_burst_len;
    (issue && is_burst) |=> tx_size == $past(b_fsz) &&
      bsent == $past(bsent) + 32'(b_fsz) + 32'(WIRE_EXTRA);
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length count wrong");
  property p_nburst;
    (running && is_burst && bmode == BM_NB && bursts >= b_cnt)
      |=> st == ST_DONE;
  endproperty
  a_nburst: assert property (p_nburst)
    else $error("counted bursts did not stop");
  property p_frames_done;
    (running && dmode == DM_FRAMES && frames >= traf_dur) |=> st == ST_DONE;
  endproperty
  a_frames_done: assert property (p_frames_done)
    else $error("frame limit not honoured");
  property p_secs_done;
    (running && dmode == DM_SECS && tot_sec >= traf_dur) |=> st == ST_DONE;
  endproperty
  a_secs_done: assert property (p_secs_done)
    else $error("seconds limit not honoured");
  property p_clamp;
    (running && is_ramp && ld_start <= ld_end && cur_load <= ld_end)
      |=> cur_load <= ld_end;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("ramp passed end load");
  property p_keep_end;
    (running && is_ramp && rmode == RM_KEEP && ramp_up &&
     cur_load == ld_end) |=> cur_load == ld_end;
  endproperty
  a_keep_end: assert property (p_keep_end)
    else $error("keep end lost end load");
  property p_ramp_step;
    (running && is_ramp && ld_due && cur_load != ld_tgt)
      |=> cur_load != $past(cur_load);
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp did not step");
  c_burst: cover property (issue && is_burst ##1 pend && tx_ready);
  c_invert: cover property (running && ld_due && rmode == RM_INVERT &&
                            cur_load == ld_tgt);
  c_done: cover property (st == ST_RUN ##1 st == ST_DONE);
endmodule

// file: verification/ests_sink.sv
// frame sink standing in for the network under test
`timescale 1ns/10ps
module ests_sink (
  input  wire logic        sys_clk,
  input  wire logic        clr,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_size,
  output logic             tx_ready,
  output int               count,
  output logic      [15:0] lo,
  output logic      [15:0] hi,
  output logic             wrapped
);
  logic [1:0]  ph = 2'd0;
  logic [15:0] last;
  // slow mode accepts one cycle in four
  always @(posedge sys_clk) begin
    ph <= ph + 2'd1;
    tx_ready <= !slow || ph == 2'd0;
    if (clr) begin
      count <= 0;
      lo <= 16'hffff;
      hi <= 16'h0000;
      wrapped <= 1'b0;
      last <= 16'h0000;
    end else if (tx_valid && tx_ready) begin
      count <= count + 1;
      last <= tx_size;
      if (tx_size < lo)
        lo <= tx_size;
      if (tx_size > hi)
        hi <= tx_size;
      if (tx_size < last)
        wrapped <= 1'b1;
    end
  end
endmodule

// file: verification/tb_ests_shaper.sv
// self-checking bench of the stream traffic shaper
`timescale 1ns/10ps
module tb_ests_shaper
  import ests_pkg::*;
;
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        tx_valid, tx_ready, clr, slow, wrapped, rerr;
  logic [15:0] tx_size, lo, hi;
  int          count, num_errors, check_count;

  ests_shaper #(.CYC_PER_MS(4)) ests_shaper_i (.sys_clk(sys_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_size(tx_size));
  ests_sink ests_sink_i (.sys_clk(sys_clk), .clr(clr), .slow(slow),
    .tx_valid(tx_valid), .tx_size(tx_size), .tx_ready(tx_ready),
    .count(count), .lo(lo), .hi(hi), .wrapped(wrapped));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      num_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  function automatic logic [31:0] ctl(input int b, pr, rp, rm, fm, dm, bm);
    ctl = 32'(1 | b << CTL_BURST | pr << CTL_PROF | rp << CTL_RAMP |
      rm << CTL_RMODE | fm << CTL_FMODE | dm << CTL_DMODE | bm << CTL_BMODE);
  endfunction

  // stop, clear the sink, then start with a fresh run edge
  task automatic run(input logic [31:0] c);
    wr(R_CTRL, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(R_CTRL, c);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, R_STATUS, 32'h0000_0000);
      n++;
    end while (rdat[1] !== 1'b1 && n < 3000);
    chk(rdat[1], 1'b1);
  endtask

  task automatic t_regs();
    rd(R_LD_END, 32'h0000_0000);
    wr(R_LD_END, 32'h0000_1234);
    rd(R_LD_END, 32'h0000_1234);
    apb(1'b0, 8'h4c, 32'h0000_0000);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0000_0000);
    wr(R_FRAMES, 32'h0000_0005);
    rd(R_FRAMES, 32'h0000_0000);
    wr(R_LD_END, 32'h0000_2710);
  endtask

  task automatic t_frames();
    slow <= 1'b1;
    wr(R_FS_START, 32'h0000_0040);
    wr(R_TRAF_DUR, 32'h0000_0005);
    run(ctl(0, 0, 0, 0, FM_CONST, DM_FRAMES, 0));
    wait_done();
    chk(count, 5);
    chk({lo, hi}, 32'h0040_0040);
    rd(R_FRAMES, 32'h0000_0005);
    slow <= 1'b0;
  endtask

  task automatic t_step();
    wr(R_FS_END, 32'h0000_0064);
    wr(R_FS_STEP, 32'h0000_001e);
    wr(R_FS_DUR, 32'h0000_0001);
    run(ctl(0, 0, 0, 0, FM_STEP, DM_CONT, 0));
    repeat (13000) @(posedge sys_clk);
    chk(lo, 16'h0040);
    chk(hi, 16'h0064);
    chk(wrapped, 1'b1);
  endtask

  task automatic t_secs();
    int c;
    wr(R_TRAF_DUR, 32'h0000_0001);
    run(ctl(0, 0, 0, 0, FM_CONST, DM_SECS, 0));
    wait_done();
    c = count;
    repeat (200) @(posedge sys_clk);
    chk(count, c);
    chk(c > 100, 1'b1);
  endtask

  task automatic t_rand();
    wr(R_FS_START, 32'h0000_0064);
    wr(R_FS_END, 32'h0000_006e);
    wr(R_TRAF_DUR, 32'h0000_0028);
    run(ctl(0, 0, 0, 0, FM_RAND, DM_FRAMES, 0));
    wait_done();
    chk(count, 40);
    chk(lo >= 16'h0064 && hi <= 16'h006e && lo != hi, 1'b1);
  endtask

  task automatic t_silent();
    run(ctl(1, 0, 0, 0, FM_CONST, DM_CONT, BM_OFF));
    repeat (300) @(posedge sys_clk);
    chk(count, 0);
    wr(R_LD_END, 32'h0000_0000);
    run(ctl(0, 0, 0, 0, FM_CONST, DM_CONT, 0));
    repeat (300) @(posedge sys_clk);
    chk(count, 0);
    wr(R_LD_END, 32'h0000_2710);
  endtask

  task automatic t_burst();
    slow <= 1'b1;
    wr(R_B_PERIOD, 32'h0000_03e8);
    wr(R_B_DUTY, 32'h0000_0032);
    wr(R_B_FSZ, 32'h0000_0050);
    wr(R_B_CNT, 32'h0000_0002);
    run(ctl(1, 0, 0, 0, FM_CONST, DM_CONT, BM_NB));
    wait_done();
    repeat (200) @(posedge sys_clk);
    chk(count, 10);
    slow <= 1'b0;
  endtask

  // constant bursts: five frames in each 200-cycle period
  task automatic t_cburst();
    run(ctl(1, 0, 0, 0, FM_CONST, DM_CONT, BM_CONST));
    repeat (2100) @(posedge sys_clk);
    chk(count, 55);
  endtask

  // invert walks back through mid loads; repeat jumps to start
  task automatic t_ramp(input logic [1:0] m, input logic mid);
    logic seen_mid, seen_top, seen_back;
    seen_mid = 1'b0;
    seen_top = 1'b0;
    seen_back = 1'b0;
    run(ctl(0, 0, 1, m, FM_CONST, DM_CONT, 0));
    repeat (20) begin
      apb(1'b0, R_CUR_LOAD, 32'h0000_0000);
      if (rdat == 32'h0000_05dc)
        seen_mid = 1'b1;
      if (rdat == 32'h0000_0bb8)
        seen_top = 1'b1;
      if (rdat == 32'h0000_03e8 && seen_top)
        seen_back = 1'b1;
    end
    chk(seen_mid, mid);
    chk(seen_back, 1'b1);
  endtask

  task automatic t_load();
    wr(R_LD_START, 32'h0000_03e8);
    wr(R_LD_END, 32'h0000_0bb8);
    wr(R_LD_STEP, 32'h0000_05dc);
    wr(R_LD_DUR, 32'h0000_0001);
    run(ctl(0, 0, 1, RM_KEEP, FM_CONST, DM_CONT, 0));
    repeat (200) @(posedge sys_clk);
    rd(R_CUR_LOAD, 32'h0000_0bb8);
    wr(R_ENC, 32'h0000_0201);
    run(ctl(0, PR_VIDEO, 0, 0, FM_CONST, DM_CONT, 0));
    repeat (20) @(posedge sys_clk);
    rd(R_CUR_LOAD, 32'h0000_0320);
    run(ctl(0, PR_VOICE, 0, 0, FM_CONST, DM_CONT, 0));
    repeat (20) @(posedge sys_clk);
    rd(R_CUR_LOAD, 32'h0000_0320);
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    {srst, clr, psel, penable, pwrite, slow} = 6'b110000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    check_count = 0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    clr <= 1'b0;
    t_regs();
    t_frames();
    t_step();
    t_secs();
    t_rand();
    t_silent();
    t_burst();
    t_cburst();
    t_load();
    t_ramp(RM_INVERT, 1'b1);
    t_ramp(RM_REPEAT, 1'b0);
    results();
  end
endmodule
